// ===== logic/sbaa_crc.sv
// Serial check field engine over every bit seen on the bus outside the error wait.
// Assumes en pulses once per sampled bit; clr at start of frame.
`timescale 1ns/1ps
module sbaa_crc (
	input wire logic sys_clk,
	input wire logic reset_n,
	sbaa_crc_if.engine cif
);
	typedef struct packed {
		logic [14:0] crc;
	} sbaa_crc_t;

	sbaa_crc_t q;
	sbaa_crc_t n;
	logic [14:0] step;

	always_comb begin
		step = {q.crc[13:0], 1'b0} ^
			(sbaa_pkg::CRC_POLY & {15{q.crc[14] ^ cif.din}});
		n = q;
		if (cif.clr) begin
			n.crc = sbaa_pkg::CRC_INIT;
		end else if (cif.en) begin
			n.crc = step;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '{crc: 15'h7fff};
		end else begin
			q <= n;
		end
	end

	assign cif.crc = q.crc;
	assign cif.nxt = step;
endmodule

// ===== logic/sbaa_crc_if.sv
// Carrier between the access controller and its check field engine.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface sbaa_crc_if;
	logic clr;
	logic en;
	logic din;
	logic [14:0] crc;
	logic [14:0] nxt;
	modport user (output clr, output en, output din, input crc, input nxt);
	modport engine (input clr, input en, input din, output crc, output nxt);
endinterface

// ===== logic/sbaa_mac.sv
// Media access controller: deferral, gap, arbitration, in-frame
// response, acknowledge, check field and identifier filtering.
// Assumes the line coder: line_en/line_bit drive a bit, rx_valid
// returns the sampled bus bit, sof/eod/ack_slot/eof mark symbols.
`timescale 1ns/1ps
module sbaa_mac (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic slave_mode,
	input wire logic tx_req,
	input wire logic [11:0] tx_id,
	input wire logic [3:0] tx_cmd,
	input wire logic tx_data_valid,
	input wire logic [7:0] tx_data,
	input wire logic resp_ready,
	input wire logic [47:0] cons_ids,
	input wire logic [47:0] prod_ids,
	input wire logic bus_busy,
	input wire logic gap_tick,
	input wire logic sof_seen,
	input wire logic rx_valid,
	input wire logic rx_bit,
	input wire logic rx_viol,
	input wire logic eod_seen,
	input wire logic ack_slot,
	input wire logic ack_seen,
	input wire logic eof_seen,
	input wire logic viol_done,
	output logic line_en,
	output logic line_bit,
	output logic line_eod,
	output logic ack_drive,
	output logic tx_data_ready,
	output logic tx_done,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic [11:0] rx_id,
	output logic [3:0] rx_cmd,
	output logic rx_ok,
	output logic err_valid,
	output logic [2:0] err_type
);
	typedef struct packed {
		sbaa_pkg::sbaa_state_t st;
		logic [5:0] gap;
		logic [7:0] cnt;
		logic over;
		logic [23:0] shf;
		logic [15:0] hdr;
		logic [7:0] txb;
		logic [2:0] bpos;
		logic fph;
		logic [3:0] fcnt;
		logic [14:0] frame_check_field;
		logic sel;
		logic viol;
		logic good;
		logic ack_request_bit;
		logic own;
		logic intent;
		logic ackd;
		logic line_en;
		logic line_bit;
		logic line_eod;
		logic ack_drive;
		logic tx_data_ready;
		logic tx_done;
		logic rx_byte_valid;
		logic [7:0] rx_byte;
		logic [11:0] rx_id;
		logic [3:0] rx_cmd;
		logic rx_ok;
		logic err_valid;
		sbaa_pkg::sbaa_err_t err_type;
	} sbaa_mac_t;

	sbaa_mac_t q;
	sbaa_mac_t n;
	logic [23:0] nshf;
	logic [7:0] ncnt;
	logic gap_ok;
	logic len_ok;
	sbaa_crc_if cif ();

	function automatic logic id_hit(input logic [47:0] tbl,
			input logic [11:0] id);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < sbaa_pkg::TBL_N; i++) begin
			if (tbl[i*sbaa_pkg::ID_W +: sbaa_pkg::ID_W] == id) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	sbaa_crc u_crc (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.cif(cif)
	);

	assign cif.clr = sof_seen;
	assign cif.en = rx_valid && q.st != sbaa_pkg::SBAA_ERRW;
	assign cif.din = rx_bit;

	always_comb begin
		n = q;
		n.line_eod = 1'b0;
		n.tx_data_ready = 1'b0;
		n.tx_done = 1'b0;
		n.rx_byte_valid = 1'b0;
		n.rx_ok = 1'b0;
		n.err_valid = 1'b0;
		nshf = {q.shf[22:0], rx_bit};
		ncnt = q.cnt + 8'h01;
		gap_ok = !bus_busy && q.gap == sbaa_pkg::GAP_PERIODS;
		len_ok = !q.over && q.cnt >= sbaa_pkg::MIN_BITS &&
			q.cnt[2:0] == sbaa_pkg::MIN_BITS[2:0];
		if (bus_busy) begin
			n.gap = 6'h00;
		end else if (gap_tick && q.gap != sbaa_pkg::GAP_PERIODS) begin
			n.gap = q.gap + 6'h01;
		end
		if (q.st != sbaa_pkg::SBAA_ERRW) begin
			if (sof_seen) begin
				n.cnt = 8'h00;
				n.over = 1'b0;
				n.sel = 1'b0;
				n.viol = 1'b0;
				n.good = 1'b0;
				n.ack_request_bit = 1'b0;
				n.ackd = 1'b0;
				n.intent = 1'b0;
			end else if (rx_valid) begin
				n.shf = nshf;
				if (q.cnt == sbaa_pkg::MAX_BITS) begin
					n.over = 1'b1;
				end else begin
					n.cnt = ncnt;
				end
				if (rx_viol) begin
					n.viol = 1'b1;
				end
				if (ncnt == sbaa_pkg::HDR_BITS) begin
					n.sel = q.own || id_hit(cons_ids, nshf[15:4]);
					n.ack_request_bit = nshf[sbaa_pkg::CMD_RAK];
					if (q.own || id_hit(cons_ids, nshf[15:4])) begin
						n.rx_id = nshf[15:4];
						n.rx_cmd = nshf[3:0];
					end
				end
				// A byte is released once the 15 following bits proved it is
				// not part of the check field
				if (q.sel && ncnt >= sbaa_pkg::FIRST_BYTE_END &&
						ncnt[2:0] == sbaa_pkg::MIN_BITS[2:0]) begin
					n.rx_byte = nshf[22:15];
					n.rx_byte_valid = 1'b1;
				end
			end
			if (eod_seen) begin
				n.good = cif.crc == sbaa_pkg::CRC_RESIDUE;
				n.ack_drive = cif.crc == sbaa_pkg::CRC_RESIDUE && len_ok &&
					!q.viol && q.ack_request_bit && q.sel && !q.own;
			end
			if (ack_slot) begin
				n.ackd = ack_seen;
				n.ack_drive = 1'b0;
			end
		end

		case (q.st)
			sbaa_pkg::SBAA_IDLE: begin
				if (sof_seen) begin
					n.st = sbaa_pkg::SBAA_RECV;
				end else if (tx_req && !slave_mode && gap_ok) begin
					n.st = sbaa_pkg::SBAA_SEND;
					n.own = 1'b1;
					n.hdr = {tx_id, tx_cmd};
					n.line_en = 1'b1;
					n.line_bit = tx_id[11];
					n.bpos = 3'h0;
					n.fph = 1'b0;
				end
			end
			sbaa_pkg::SBAA_RECV: begin
				if (rx_valid && ncnt == sbaa_pkg::RTR_POS && !q.own &&
						resp_ready && nshf[0] &&
						id_hit(prod_ids, nshf[14:3])) begin
					n.st = sbaa_pkg::SBAA_RESP;
					n.own = 1'b1;
					n.hdr = 16'h0000;
					n.line_en = 1'b1;
					n.line_bit = 1'b0;
					n.bpos = 3'h0;
					n.fph = 1'b0;
				end
			end
			sbaa_pkg::SBAA_SEND, sbaa_pkg::SBAA_RESP: begin
				if (rx_valid && q.line_en) begin
					// A coding violation aborts the frame even when the bit matches
					if (rx_bit != q.line_bit || rx_viol) begin
						n.line_en = 1'b0;
						if (rx_viol || !q.line_bit) begin
							n.st = sbaa_pkg::SBAA_ERRW;
							n.own = 1'b0;
							n.err_valid = 1'b1;
							n.err_type = sbaa_pkg::SBAA_ERR_TX;
						end else begin
							// Dominant zero won over our recessive one
							n.st = sbaa_pkg::SBAA_RECV;
							n.own = 1'b0;
							n.intent = q.cnt == sbaa_pkg::RTR_POS &&
								q.hdr[sbaa_pkg::CMD_RTR];
						end
					end else if (!q.fph && ncnt < sbaa_pkg::HDR_BITS) begin
						n.line_bit = q.hdr[4'hf - ncnt[3:0]];
					end else if (q.fph) begin
						if (q.fcnt == 4'h0) begin
							n.line_en = 1'b0;
							n.line_eod = 1'b1;
							n.st = sbaa_pkg::SBAA_TAIL;
						end else begin
							n.line_bit = q.frame_check_field[14];
							n.frame_check_field = {q.frame_check_field[13:0], 1'b0};
							n.fcnt = q.fcnt - 4'h1;
						end
					end else if (q.bpos != 3'h0) begin
						n.line_bit = q.txb[7];
						n.txb = {q.txb[6:0], 1'b0};
						n.bpos = q.bpos - 3'h1;
					end else if (!(q.st == sbaa_pkg::SBAA_SEND &&
							q.hdr[sbaa_pkg::CMD_RTR]) && tx_data_valid &&
							ncnt <= sbaa_pkg::LAST_LOAD) begin
						n.tx_data_ready = 1'b1;
						n.line_bit = tx_data[7];
						n.txb = {tx_data[6:0], 1'b0};
						n.bpos = 3'h7;
					end else begin
						// Frame ends here with its check field once no data byte follows, as for an unanswered request
						n.fph = 1'b1;
						n.line_bit = cif.nxt[14];
						n.frame_check_field = {cif.nxt[13:0], 1'b0};
						n.fcnt = sbaa_pkg::FCS_LAST;
					end
				end
			end
			sbaa_pkg::SBAA_TAIL: begin
			end
			sbaa_pkg::SBAA_ERRW: begin
				n.line_en = 1'b0;
				if (viol_done) begin
					n.st = sbaa_pkg::SBAA_IDLE;
					n.gap = 6'h00;
				end
			end
			default: begin
				n.st = sbaa_pkg::SBAA_IDLE;
			end
		endcase

		if (eof_seen && q.st != sbaa_pkg::SBAA_ERRW) begin
			n.st = sbaa_pkg::SBAA_IDLE;
			n.own = 1'b0;
			n.line_en = 1'b0;
			n.ack_drive = 1'b0;
			if (q.intent) begin
				n.tx_done = 1'b1;
			end
			if (q.cnt >= sbaa_pkg::HDR_BITS && (q.sel || q.own)) begin
				n.err_valid = 1'b1;
				if (q.viol) begin
					n.err_type = sbaa_pkg::SBAA_ERR_CODE;
				end else if (!len_ok) begin
					n.err_type = sbaa_pkg::SBAA_ERR_LEN;
				end else if (!q.good) begin
					n.err_type = sbaa_pkg::SBAA_ERR_CRC;
				end else if (q.ack_request_bit != q.ackd) begin
					n.err_type = sbaa_pkg::SBAA_ERR_ACK;
				end else begin
					n.err_valid = 1'b0;
					n.err_type = sbaa_pkg::SBAA_ERR_NONE;
					n.tx_done = q.own || q.intent;
					n.rx_ok = q.sel;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign line_en = q.line_en;
	assign line_bit = q.line_bit;
	assign line_eod = q.line_eod;
	assign ack_drive = q.ack_drive;
	assign tx_data_ready = q.tx_data_ready;
	assign tx_done = q.tx_done;
	assign rx_byte_valid = q.rx_byte_valid;
	assign rx_byte = q.rx_byte;
	assign rx_id = q.rx_id;
	assign rx_cmd = q.rx_cmd;
	assign rx_ok = q.rx_ok;
	assign err_valid = q.err_valid;
	assign err_type = q.err_type;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	chk_busy_defers:
	assert property (bus_busy && q.st == sbaa_pkg::SBAA_IDLE |=>
		q.st != sbaa_pkg::SBAA_SEND)
		else $error("Frame started on a busy bus");
	chk_gap_full:
	assert property (q.st == sbaa_pkg::SBAA_IDLE && !sof_seen ##1
		q.st == sbaa_pkg::SBAA_SEND |-> $past(q.gap) == sbaa_pkg::GAP_PERIODS)
		else $error("Frame started before the full gap");
	chk_gap_restart:
	assert property (bus_busy |=> q.gap == 6'h00)
		else $error("Gap count kept during bus activity");
	chk_stop_mismatch:
	assert property (q.line_en && rx_valid && rx_bit != q.line_bit &&
		(q.st == sbaa_pkg::SBAA_SEND || q.st == sbaa_pkg::SBAA_RESP) &&
		!eof_seen |=> !q.line_en)
		else $error("Still driving after a bit mismatch");
	chk_lost_receives:
	assert property (q.st == sbaa_pkg::SBAA_SEND && q.line_en && rx_valid &&
		q.line_bit && !rx_bit && !rx_viol && !eof_seen |=>
		q.st == sbaa_pkg::SBAA_RECV)
		else $error("Lost node did not go on receiving");
	chk_resp_dominant:
	assert property (q.st == sbaa_pkg::SBAA_RECV && rx_valid && !q.own &&
		ncnt == sbaa_pkg::RTR_POS && resp_ready && nshf[0] &&
		id_hit(prod_ids, nshf[14:3]) && !eof_seen |=>
		q.line_en && !q.line_bit)
		else $error("Polled node did not drive dominant request bit");
	chk_slave_quiet:
	assert property (slave_mode |=> !(q.st == sbaa_pkg::SBAA_SEND &&
		$past(q.st) == sbaa_pkg::SBAA_IDLE))
		else $error("Slave node started a frame");
	chk_short_silent:
	assert property (eof_seen && q.cnt < sbaa_pkg::HDR_BITS |=>
		!q.err_valid && !q.rx_ok)
		else $error("Short frame was reported");
	chk_err_holds:
	assert property (q.st == sbaa_pkg::SBAA_ERRW && !viol_done |=>
		q.st == sbaa_pkg::SBAA_ERRW && !q.line_en)
		else $error("Left error wait before time-out");
endmodule

// ===== logic/sbaa_pkg.sv
// Constants and types of the serial bus access arbiter.
// Assumes a line coder that delivers one sampled bit per rx_valid pulse.
// What this block does
// - Defer frame start while bus is busy
// - Wait 61 free gap periods before sending
// - Compare every received bit with driven bit
// - Dominant zero overrides recessive one on bus
// - Stop driving at once on mismatch
// - Arbitrate every bit from identifier onward
// - After losing, keep receiving to frame end
// - Unintended loss: retry after bus release
// - No retry when polled node answered in-frame
// - Polled node drives zero at request bit
// - Overridden requester stops and receives data
// - No answer: requester completes frame alone
// - Acknowledge good addressed frames requesting it
// - Slave node never starts frames itself
// - Append check field, verify it, whole bytes
// - Drop too short frames without error
// - Filter 12-bit identifiers against both tables
// - Report code error on coding violation in a received frame
// - Report wrong or missing acknowledgement
// - Transmit error: abort, wait time-out, gap
// - Receive error: discard frame, report type
// - Frame length between 31 and 255 bits
// - Send bytes in order, MSB first
package sbaa_pkg;
	localparam int ID_W = 12;
	localparam int TBL_N = 4;
	localparam int TBL_W = ID_W * TBL_N;
	localparam logic [7:0] HDR_BITS = 8'h10;
	localparam logic [7:0] RTR_POS = 8'h0f;
	localparam logic [7:0] MIN_BITS = 8'h1f;
	localparam logic [7:0] MAX_BITS = 8'hff;
	localparam logic [7:0] LAST_LOAD = 8'he8;
	localparam logic [7:0] FIRST_BYTE_END = 8'h27;
	localparam logic [5:0] GAP_PERIODS = 6'h3d;
	localparam logic [3:0] FCS_LAST = 4'he;
	// Command field bits: extension, ack request, read, remote request
	localparam int CMD_RAK = 2;
	localparam int CMD_RTR = 0;
	// Check field generator polynomial and start value (arbitrary)
	localparam logic [14:0] CRC_POLY = 15'h0f9d;
	localparam logic [14:0] CRC_INIT = 15'h7fff;
	localparam logic [14:0] CRC_RESIDUE = 15'h0000;

	typedef enum logic [2:0] {
		SBAA_IDLE = 3'b000,
		SBAA_RECV = 3'b001,
		SBAA_SEND = 3'b010,
		SBAA_RESP = 3'b011,
		SBAA_TAIL = 3'b100,
		SBAA_ERRW = 3'b101
	} sbaa_state_t;

	typedef enum logic [2:0] {
		SBAA_ERR_NONE = 3'b000,
		SBAA_ERR_CODE = 3'b001,
		SBAA_ERR_LEN = 3'b010,
		SBAA_ERR_CRC = 3'b011,
		SBAA_ERR_ACK = 3'b100,
		SBAA_ERR_TX = 3'b101
	} sbaa_err_t;
endpackage

// ===== verif/sbaa_peer.sv
// Line coder and peer nodes sharing the wired-and line with the mac.
// Assumes the mac samples on the rising edge; this drives on falling.
`timescale 1ns/1ps
module sbaa_peer (
	input wire logic sys_clk,
	input wire logic line_en,
	input wire logic line_bit,
	input wire logic line_eod,
	input wire logic ack_drive,
	output logic bus_busy,
	output logic gap_tick,
	output logic sof_seen,
	output logic rx_valid,
	output logic rx_bit,
	output logic rx_viol,
	output logic eod_seen,
	output logic ack_slot,
	output logic ack_seen,
	output logic eof_seen,
	output logic viol_done
);
	logic pq[$];
	logic wq[$];
	logic go = 0;
	logic peer_ack = 0;
	logic ackd = 0;
	logic e = 0;
	logic v;
	int viol_at = -1;
	initial begin
		{bus_busy, gap_tick, sof_seen, rx_valid, rx_bit, rx_viol} = '0;
		{eod_seen, ack_slot, ack_seen, eof_seen, viol_done} = '0;
	end
	// Gap periods tick only while the line is free
	always @(negedge sys_clk) gap_tick <= !bus_busy && !gap_tick;
	task automatic tick;
		@(negedge sys_clk);
		e = e | line_eod;
	endtask
	task automatic blip;
		bus_busy = 1;
		repeat (4) tick();
		bus_busy = 0;
	endtask
	always begin
		wait (line_en || go);
		e = 0;
		wq = {};
		@(negedge sys_clk);
		bus_busy = 1;
		sof_seen = 1;
		tick();
		sof_seen = 0;
		while (!e && (line_en || pq.size() > 0)) begin
			v = pq.size() > 0 ? pq.pop_front() : 1'b1;
			v = v & (line_en ? line_bit : 1'b1);
			rx_viol = wq.size() == viol_at;
			wq.push_back(v);
			rx_bit = v;
			rx_valid = 1;
			tick();
			{rx_valid, rx_viol} = '0;
			// Released line shows the inverse, not a stale bit
			rx_bit = ~v;
			repeat (2) tick();
		end
		eod_seen = 1;
		tick();
		eod_seen = 0;
		tick();
		ackd = ack_drive;
		ack_slot = 1;
		ack_seen = ack_drive | peer_ack;
		tick();
		{ack_slot, ack_seen} = '0;
		tick();
		eof_seen = 1;
		tick();
		eof_seen = 0;
		viol_done = viol_at >= 0;
		tick();
		{viol_done, bus_busy, go, peer_ack} = '0;
		viol_at = -1;
	end
endmodule

// ===== verif/tb_serial_bus_access_arbiter.sv
// Self-checking bench of the bus access controller.
// Assumes sbaa_peer plays the line coder and the peer nodes.
`timescale 1ns/1ps
module tb_serial_bus_access_arbiter;
	logic sys_clk = 0;
	logic reset_n = 0;
	logic slave_mode = 0;
	logic tx_req = 0;
	logic [11:0] tx_id = '0;
	logic [3:0] tx_cmd = '0;
	logic tx_data_valid = 0;
	logic [7:0] tx_data = '0;
	logic resp_ready = 0;
	logic [47:0] cons_ids = '0;
	logic [47:0] prod_ids = '0;
	logic bus_busy, gap_tick, sof_seen, rx_valid, rx_bit, rx_viol, eod_seen;
	logic ack_slot, ack_seen, eof_seen, viol_done, line_en, line_bit;
	logic line_eod, ack_drive, tx_data_ready, tx_done, rx_byte_valid;
	logic rx_ok, err_valid;
	logic en_d = 0;
	logic [7:0] rx_byte;
	logic [11:0] rx_id;
	logic [3:0] rx_cmd;
	logic [2:0] err_type, last_err;
	logic [1:0] lost = '0;
	logic fq[$], sq[$];
	logic [7:0] bq[$], rq[$];
	int fail_count = 0;
	int tests_run = 0;
	int seed = 12;
	int cyc = 0;
	int oks = 0, errs = 0, dones = 0, rise = 0, mark = 0;
	int d0, o0, e0, r0;
	sbaa_mac uut (.sys_clk, .reset_n, .slave_mode, .tx_req, .tx_id, .tx_cmd,
		.tx_data_valid, .tx_data, .resp_ready, .cons_ids, .prod_ids,
		.bus_busy, .gap_tick, .sof_seen, .rx_valid, .rx_bit, .rx_viol,
		.eod_seen, .ack_slot, .ack_seen, .eof_seen, .viol_done, .line_en,
		.line_bit, .line_eod, .ack_drive, .tx_data_ready, .tx_done,
		.rx_byte_valid, .rx_byte, .rx_id, .rx_cmd, .rx_ok, .err_valid,
		.err_type);
	sbaa_peer peer (.sys_clk, .line_en, .line_bit, .line_eod, .ack_drive,
		.bus_busy, .gap_tick, .sof_seen, .rx_valid, .rx_bit, .rx_viol,
		.eod_seen, .ack_slot, .ack_seen, .eof_seen, .viol_done);
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		en_d <= line_en;
		if (line_en && !en_d) rise = cyc;
		if (rx_byte_valid) rq.push_back(rx_byte);
		if (rx_ok) oks++;
		if (tx_done) dones++;
		if (err_valid) errs++;
		if (err_valid) last_err <= err_type;
		if (tx_data_ready) tx_data_valid <= 0;
		if (viol_done) mark = cyc;
		lost <= {lost[0], rx_valid && line_en && rx_bit !== line_bit};
		if (lost[1]) check(line_en, 1'b0);
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end
	task put(input logic d, inout logic [14:0] c);
		fq.push_back(d);
		c = {c[13:0], 1'b0} ^ (d ^ c[14] ? sbaa_pkg::CRC_POLY : 15'h0000);
	endtask
	task mk(input logic [15:0] h, input int nb, input int pad);
		logic [14:0] c;
		logic [7:0] b;
		c = sbaa_pkg::CRC_INIT;
		fq = {};
		bq = {};
		for (int i = 15; i >= 0; i--) put(h[i], c);
		for (int k = 0; k < nb; k++) begin
			b = $random(seed);
			bq.push_back(b);
			for (int i = 7; i >= 0; i--) put(b[i], c);
		end
		repeat (pad) put(1'b1, c);
		for (int i = 14; i >= 0; i--) fq.push_back(c[i]);
	endtask
	task idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task frame;
		int k;
		k = 0;
		while (!bus_busy && k < 400) begin
			idle(1);
			k++;
		end
		while (bus_busy && k < 3000) begin
			idle(1);
			k++;
		end
		idle(4);
	endtask
	task rx_case(input int kind);
		logic [2:0] ex;
		logic [11:0] id;
		ex = kind == 2 ? 3'h3 : kind == 3 ? 3'h1 : kind == 4 ? 3'h4 : 3'h0;
		if (kind == 5) ex = 3'h2;
		id = kind == 1 ? ~cons_ids[35:24] : cons_ids[35:24];
		mk({id, kind == 4 ? 4'h0 : 4'h4}, 2, kind == 5 ? 3 : 0);
		if (kind == 2) fq[30] = ~fq[30];
		if (kind == 6) fq = fq[0:9];
		peer.viol_at = kind == 3 ? 20 : -1;
		peer.peer_ack = kind == 4;
		o0 = oks;
		e0 = errs;
		rq = {};
		peer.pq = fq;
		peer.go = 1;
		frame();
		check(oks - o0, kind == 0);
		check(errs - e0, ex != 0);
		if (ex != 0) check(last_err, ex);
		if (kind == 0) begin
			check(rx_id, id);
			check(rq.size(), 2);
			check({rq[0], rq[1]}, {bq[0], bq[1]});
			check(peer.ackd, 1'b1);
		end
	endtask
	initial begin
		cons_ids = 48'({$random(seed), $random(seed)});
		cons_ids[0] = 1'b0;
		prod_ids = 48'({$random(seed), $random(seed)});
		idle(20);
		reset_n = 1;
		idle(150);
		for (int k = 0; k <= 6; k++) rx_case(k);
		// Own frame defers to a busy line, then a restarted gap
		tx_id = $random(seed);
		mk({tx_id, tx_cmd}, 1, 0);
		sq = fq;
		tx_data = bq[0];
		tx_data_valid = 1;
		mk(16'h5a50, 1, 0);
		peer.pq = fq;
		peer.go = 1;
		wait (bus_busy);
		tx_req = 1;
		{r0, d0} = {rise, dones};
		frame();
		check(rise, r0);
		idle(60);
		peer.blip();
		mark = cyc;
		frame();
		tx_req = 0;
		check(rise - mark >= 118 && rise - mark <= 130, 1);
		check(dones - d0, 1);
		check(peer.wq.size(), sq.size());
		foreach (sq[i]) check(peer.wq[i], sq[i]);
		// Lose to a lower identifier, receive it, then retry
		tx_id = cons_ids[11:0] ^ 12'h001;
		mk({tx_id, 4'h0}, 1, 0);
		sq = fq;
		tx_data = bq[0];
		tx_data_valid = 1;
		mk({cons_ids[11:0], 4'h0}, 1, 0);
		peer.pq = fq;
		{d0, o0} = {dones, oks};
		rq = {};
		tx_req = 1;
		frame();
		check(dones - d0, 0);
		check(oks - o0, 1);
		check(rq[0], bq[0]);
		frame();
		tx_req = 0;
		check(dones - d0, 1);
		foreach (sq[i]) check(peer.wq[i], sq[i]);
		// Polled peer answers in-frame at the remote request bit
		tx_id = $random(seed);
		tx_cmd = 4'h1;
		mk({tx_id, 4'h0}, 1, 0);
		for (int i = 0; i < 15; i++) fq[i] = 1'b1;
		peer.pq = fq;
		d0 = dones;
		tx_req = 1;
		frame();
		tx_req = 0;
		r0 = rise;
		idle(300);
		check(dones - d0, 1);
		check(rise, r0);
		slave_mode = 1;
		tx_req = 1;
		idle(300);
		check(rise, r0);
		{tx_req, slave_mode, tx_cmd} = '0;
		// Coding fault on own frame: abort, time-out, then gap
		mk({tx_id, 4'h0}, 1, 0);
		tx_data = bq[0];
		tx_data_valid = 1;
		peer.viol_at = 5;
		{e0, d0} = {errs, dones};
		tx_req = 1;
		frame();
		check(errs - e0, 1);
		check(last_err, 3'h5);
		frame();
		tx_req = 0;
		check(rise - mark >= 118 && rise - mark <= 132, 1);
		check(dones - d0, 1);
		conclude();
	end
endmodule
